// ==== verilog/hsttc_defs.vh ====
`ifndef HSTTC_DEFS_VH
`define HSTTC_DEFS_VH

// Message tags of the tuner control resource.
`define HSTTC_TAG_UP_REQ     24'h9F8404
`define HSTTC_TAG_UP_CNF     24'h9F8405
`define HSTTC_TAG_DN_REQ     24'h9F8406
`define HSTTC_TAG_DN_CNF     24'h9F8407
`define HSTTC_TAG_IB_REQ     24'h9F8408
`define HSTTC_TAG_IB_CNF     24'h9F8409

// Resource identity in single-stream and multi-stream mode.
`define HSTTC_RES_CLASS      10'h020
`define HSTTC_RES_TYPE_S     10'h001
`define HSTTC_RES_VER_S      6'h03
`define HSTTC_RES_TYPE_M     10'h002
`define HSTTC_RES_VER_M      6'h01
`define HSTTC_RID_SINGLE     32'h00200043
`define HSTTC_RID_MULTI      32'h00200081

// Payload lengths carried in the length field.
`define HSTTC_LEN_UP         8'h04
`define HSTTC_LEN_DN         8'h03
`define HSTTC_LEN_IB         8'h04
`define HSTTC_LEN_CNF        16'h0001
`define HSTTC_LEN_LONG_BIT   7
`define HSTTC_LEN_NUM_MSB    1

// Total bytes on the wire per request kind.
`define HSTTC_BYTES_UP       4'h8
`define HSTTC_BYTES_DN       4'h7
`define HSTTC_BYTES_IB       4'h8

// Confirmation status codes.
`define HSTTC_ST_GRANTED     8'h00
`define HSTTC_ST_ABSENT      8'h01
`define HSTTC_ST_BUSY        8'h02
`define HSTTC_ST_RANGE       8'h03
`define HSTTC_ST_OTHER       8'h04

// Upstream rate byte layout.
`define HSTTC_RATE_MSB       7
`define HSTTC_RATE_LSB       6
`define HSTTC_RATE_RSVD      2'h1
`define HSTTC_RATE_256K      2'h0
`define HSTTC_RATE_1544K     2'h2
`define HSTTC_RATE_3088K     2'h3
`define HSTTC_RATE_LOW_ZERO  6'h00

// Inband tune type selecting frequency tuning.
`define HSTTC_IB_TYPE_FREQ   8'h01

// Message kinds.
`define HSTTC_KIND_UP        2'h0
`define HSTTC_KIND_DN        2'h1
`define HSTTC_KIND_IB        2'h2
`define HSTTC_KIND_NONE      2'h3

`endif

// ==== verilog/hsttc_cnf_parse.v ====
`timescale 1ns/1ps
`include "hsttc_defs.vh"

// Parser for confirmations arriving from the host as a byte stream.
module hsttc_cnf_parse (
   // Clock and reset.
   input  wire       clk_i,
   input  wire       rst_b_i,
   // Incoming byte stream.
   input  wire [7:0] rx_data_i,
   input  wire       rx_valid_i,
   // Decoded confirmation.
   output reg        cnf_valid_o,
   output reg  [1:0] cnf_kind_o,
   output reg  [7:0] cnf_status_o,
   output reg        drop_o
);

   // Parser states.
   localparam P_TAG  = 3'h0;
   localparam P_LEN  = 3'h1;
   localparam P_LLEN = 3'h2;
   localparam P_BODY = 3'h3;
   localparam P_SKIP = 3'h4;

   reg  [2:0]  state_r;   // Current parser state.
   reg  [23:0] tag_r;     // Tag collected so far.
   reg  [1:0]  tcnt_r;    // Tag bytes received.
   reg  [1:0]  lcnt_r;    // Long-form length bytes still due.
   reg  [15:0] len_r;     // Payload bytes still due.
   wire [1:0]  kind;      // Confirmation kind of the collected tag.

   // Maps a tag to the confirmation kind it names.
   function [1:0] cnf_kind_of;
      input [23:0] tag;
      begin
         case (tag)
            `HSTTC_TAG_UP_CNF: cnf_kind_of = `HSTTC_KIND_UP;
            `HSTTC_TAG_DN_CNF: cnf_kind_of = `HSTTC_KIND_DN;
            `HSTTC_TAG_IB_CNF: cnf_kind_of = `HSTTC_KIND_IB;
            default:           cnf_kind_of = `HSTTC_KIND_NONE;
         endcase
      end
   endfunction

   assign kind = cnf_kind_of(tag_r);

   // Walks tag, length and payload; unknown tags are skipped by length.
   always @(posedge clk_i) begin
      cnf_valid_o <= 1'b0;
      drop_o      <= 1'b0;
      if (!rst_b_i) begin
         state_r      <= P_TAG;
         tag_r        <= 24'h000000;
         tcnt_r       <= 2'h0;
         lcnt_r       <= 2'h0;
         len_r        <= 16'h0000;
         cnf_kind_o   <= `HSTTC_KIND_NONE;
         cnf_status_o <= 8'h00;
      end else if (rx_valid_i) begin
         case (state_r)
            // Three tag bytes, most significant first.
            P_TAG: begin
               tag_r <= {tag_r[15:0], rx_data_i};
               if (tcnt_r == 2'h2) begin
                  tcnt_r  <= 2'h0;
                  state_r <= P_LEN;
               end else begin
                  tcnt_r <= tcnt_r + 2'h1;
               end
            end
            // Short form gives the count; long form gives bytes to follow.
            P_LEN: begin
               len_r <= 16'h0000;
               if (rx_data_i[`HSTTC_LEN_LONG_BIT]) begin
                  lcnt_r  <= rx_data_i[`HSTTC_LEN_NUM_MSB:0];
                  state_r <= P_LLEN;
                  if (rx_data_i[`HSTTC_LEN_NUM_MSB:0] == 2'h0) begin
                     state_r <= P_TAG;
                     drop_o  <= 1'b1;
                  end
               end else if (rx_data_i == 8'h00) begin
                  state_r <= P_TAG;
                  drop_o  <= 1'b1;
               end else if (kind != `HSTTC_KIND_NONE &&
                            {8'h00, rx_data_i} == `HSTTC_LEN_CNF) begin
                  state_r <= P_BODY;
               end else begin
                  len_r   <= {8'h00, rx_data_i};
                  state_r <= P_SKIP;
               end
            end
            // Long-form length bytes, most significant first.
            P_LLEN: begin
               len_r  <= {len_r[7:0], rx_data_i};
               lcnt_r <= lcnt_r - 2'h1;
               if (lcnt_r == 2'h1) begin
                  if ({len_r[7:0], rx_data_i} == 16'h0000) begin
                     state_r <= P_TAG;
                     drop_o  <= 1'b1;
                  end else if (kind != `HSTTC_KIND_NONE &&
                               {len_r[7:0], rx_data_i} ==
                               `HSTTC_LEN_CNF) begin
                     state_r <= P_BODY;
                  end else begin
                     state_r <= P_SKIP;
                  end
               end
            end
            // Status byte of a known confirmation.
            P_BODY: begin
               cnf_valid_o  <= 1'b1;
               cnf_kind_o   <= kind;
               cnf_status_o <= rx_data_i;
               state_r      <= P_TAG;
            end
            // Payload of a message that is discarded.
            P_SKIP: begin
               len_r <= len_r - 16'h0001;
               if (len_r == 16'h0001) begin
                  state_r <= P_TAG;
                  drop_o  <= 1'b1;
               end
            end
            default: begin
               state_r <= P_TAG;
            end
         endcase
      end
   end

endmodule

// ==== verilog/hsttc_card_ctrl.v ====
// Functional notes
// - Only one tuner control session at once.
// - Single-stream resource id is 0x00200043.
// - Multi-stream resource id is 0x00200081.
// - Session stays open regardless of homing.
// - Upstream request 0x9F8404, confirm 0x9F8405.
// - Downstream request 0x9F8406, confirm 0x9F8407.
// - Inband request 0x9F8408, confirm 0x9F8409.
// - Without alternate signaling, configure upstream transmitter.
// - Upstream request: tag, length, freq, power, rate.
// - Rate bits 7:6 select speed; rest reserved.
// - Status 0x01 means never transmit again.
`timescale 1ns/1ps
`include "hsttc_defs.vh"

// Module-side controller that sends tune requests and reads confirmations.
module hsttc_card_ctrl (
   // Clock and reset.
   input  wire        clk_i,
   input  wire        rst_b_i,
   // Session control.
   input  wire        sess_open_req_i,
   input  wire        sess_close_req_i,
   input  wire        multi_stream_i,
   output reg         session_open_o,
   output reg         sess_dup_o,
   output reg  [31:0] resource_id_o,
   // Tune request from the user side.
   input  wire        req_valid_i,
   input  wire [1:0]  req_kind_i,
   input  wire [15:0] req_freq_i,
   input  wire [7:0]  req_level_i,
   input  wire [7:0]  req_rate_i,
   input  wire        alternate_signaling_option_i,
   output wire        req_ready_o,
   output reg         req_refused_o,
   output reg         upstream_needed_o,
   // Confirmation report to the user side.
   output wire        cnf_valid_o,
   output wire [1:0]  cnf_kind_o,
   output wire [7:0]  cnf_status_o,
   output wire        drop_o,
   output reg         upstream_absent_o,
   output reg         busy_o,
   // Byte link toward the host.
   output wire [7:0]  tx_data_o,
   output wire        tx_valid_o,
   input  wire        tx_ready_i,
   input  wire [7:0]  rx_data_i,
   input  wire        rx_valid_i
);

   // Request sequencer states.
   localparam S_IDLE = 2'h0;
   localparam S_SEND = 2'h1;
   localparam S_WAIT = 2'h2;

   reg  [1:0]  state_r;     // Sequencer state.
   reg  [63:0] shift_r;     // Message bytes, next byte on top.
   reg  [3:0]  left_r;      // Bytes still to send.
   reg  [1:0]  pend_kind_r; // Kind awaiting its confirmation.
   reg         up_done_r;   // Upstream transmitter has been configured.
   reg  [63:0] msg;         // Message built from the request.
   reg  [3:0]  msg_len;     // Byte count of that message.
   reg         refuse;      // Request cannot be sent.
   wire        take;        // Request accepted this cycle.

   // Returns the upstream rate byte with reserved low bits cleared.
   function [7:0] up_rate_byte;
      input [7:0] code;
      begin
         up_rate_byte = {code[`HSTTC_RATE_MSB:`HSTTC_RATE_LSB],
                         `HSTTC_RATE_LOW_ZERO};
      end
   endfunction

   // Tells whether a rate code selects a reserved speed.
   function rate_reserved;
      input [7:0] code;
      begin
         rate_reserved =
            (code[`HSTTC_RATE_MSB:`HSTTC_RATE_LSB] == `HSTTC_RATE_RSVD);
      end
   endfunction

   // Confirmation parser.
   hsttc_cnf_parse u_parse (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .rx_data_i    (rx_data_i),
      .rx_valid_i   (rx_valid_i),
      .cnf_valid_o  (cnf_valid_o),
      .cnf_kind_o   (cnf_kind_o),
      .cnf_status_o (cnf_status_o),
      .drop_o       (drop_o)
   );

   // Handshakes toward the user and the link.
   assign req_ready_o = (state_r == S_IDLE);
   assign take        = req_valid_i && req_ready_o;
   assign tx_valid_o  = (state_r == S_SEND);
   assign tx_data_o   = shift_r[63:56];

   // Builds the message image and decides on refusal.
   always @* begin
      msg     = 64'h0000000000000000;
      msg_len = `HSTTC_BYTES_UP;
      refuse  = !session_open_o;
      case (req_kind_i)
         // Upstream: tag, length, kHz frequency, power, rate.
         `HSTTC_KIND_UP: begin
            msg = {`HSTTC_TAG_UP_REQ, `HSTTC_LEN_UP, req_freq_i,
                   req_level_i, up_rate_byte(req_rate_i)};
            if (upstream_absent_o || rate_reserved(req_rate_i)) begin
               refuse = 1'b1;
            end
         end
         // Downstream out-of-band: tag, length, frequency, rate.
         `HSTTC_KIND_DN: begin
            msg = {`HSTTC_TAG_DN_REQ, `HSTTC_LEN_DN, req_freq_i,
                   req_rate_i, 8'h00};
            msg_len = `HSTTC_BYTES_DN;
         end
         // Inband by frequency: tag, length, type, frequency, modulation.
         `HSTTC_KIND_IB: begin
            msg = {`HSTTC_TAG_IB_REQ, `HSTTC_LEN_IB, `HSTTC_IB_TYPE_FREQ,
                   req_freq_i, req_level_i};
         end
         default: begin
            refuse = 1'b1;
         end
      endcase
   end

   // Session bookkeeping; a second open only reports a duplicate.
   always @(posedge clk_i) begin
      sess_dup_o <= 1'b0;
      if (!rst_b_i) begin
         session_open_o <= 1'b0;
         resource_id_o  <= `HSTTC_RID_SINGLE;
      end else if (sess_open_req_i) begin
         if (session_open_o) begin
            sess_dup_o <= 1'b1;
         end else begin
            session_open_o <= 1'b1;
            resource_id_o  <= multi_stream_i ? `HSTTC_RID_MULTI :
                              `HSTTC_RID_SINGLE;
         end
      end else if (sess_close_req_i) begin
         // Closing is a user decision only; homing never closes it.
         session_open_o <= 1'b0;
      end
   end

   // Request sequencer: send the bytes, then wait for the confirmation.
   always @(posedge clk_i) begin
      req_refused_o <= 1'b0;
      if (!rst_b_i) begin
         state_r     <= S_IDLE;
         shift_r     <= 64'h0000000000000000;
         left_r      <= 4'h0;
         pend_kind_r <= `HSTTC_KIND_NONE;
      end else begin
         case (state_r)
            // Accept or refuse a request.
            S_IDLE: begin
               if (take && refuse) begin
                  req_refused_o <= 1'b1;
               end else if (take) begin
                  shift_r     <= msg;
                  left_r      <= msg_len;
                  pend_kind_r <= req_kind_i;
                  state_r     <= S_SEND;
               end
            end
            // One byte leaves per accepted link cycle.
            S_SEND: begin
               if (tx_ready_i) begin
                  shift_r <= {shift_r[55:0], 8'h00};
                  left_r  <= left_r - 4'h1;
                  if (left_r == 4'h1) begin
                     state_r <= S_WAIT;
                  end
               end
            end
            // Wait for the matching confirmation or a session close.
            S_WAIT: begin
               if (cnf_valid_o && cnf_kind_o == pend_kind_r) begin
                  state_r <= S_IDLE;
               end else if (!session_open_o) begin
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // Tracks transmitter absence and whether upstream still needs setup.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         upstream_absent_o <= 1'b0;
         up_done_r         <= 1'b0;
         upstream_needed_o <= 1'b0;
         busy_o            <= 1'b0;
      end else begin
         busy_o <= (state_r != S_IDLE);
         if (cnf_valid_o && cnf_kind_o == `HSTTC_KIND_UP) begin
            if (cnf_status_o == `HSTTC_ST_ABSENT) begin
               upstream_absent_o <= 1'b1;
            end
            if (cnf_status_o == `HSTTC_ST_GRANTED) begin
               up_done_r <= 1'b1;
            end
         end
         if (!session_open_o) begin
            up_done_r <= 1'b0;
         end
         upstream_needed_o <= session_open_o &&
                              !alternate_signaling_option_i &&
                              !up_done_r && !upstream_absent_o;
      end
   end

endmodule

// ==== testbench/hsttc_card_ctrl_monitor.sv ====
`timescale 1ns/1ps
// Watches the controller's ports for protocol slips.
module hsttc_mon (
   // Clock and reset.
   input wire        clk_i,
   input wire        rst_b_i,
   // Session side.
   input wire        sess_open_req_i,
   input wire        multi_stream_i,
   input wire        session_open_o,
   input wire        sess_dup_o,
   input wire [31:0] resource_id_o,
   // Request side.
   input wire        req_valid_i,
   input wire [1:0]  req_kind_i,
   input wire [7:0]  req_rate_i,
   input wire        req_ready_o,
   input wire        req_refused_o,
   // Confirmations and link.
   input wire        cnf_valid_o,
   input wire [1:0]  cnf_kind_o,
   input wire [7:0]  cnf_status_o,
   input wire        drop_o,
   input wire        upstream_absent_o,
   input wire [7:0]  tx_data_o,
   input wire        tx_valid_o,
   input wire        tx_ready_i,
   input wire [7:0]  rx_data_i,
   input wire        rx_valid_i
);
   // One clock domain for every check.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // First two tag bytes shared by every confirmation.
   sequence s_hdr;
      rx_valid_i && rx_data_i == 8'h9F ##1 rx_valid_i && rx_data_i == 8'h84;
   endsequence
   property p_open;
      sess_open_req_i && !session_open_o |=> session_open_o;
   endproperty
   a_open: assert property (p_open) else $error("open not taken");
   property p_dup;
      sess_open_req_i && session_open_o |=> sess_dup_o && session_open_o;
   endproperty
   a_dup: assert property (p_dup) else $error("second open");
   property p_rid;
      $rose(session_open_o) |-> resource_id_o ==
         ($past(multi_stream_i) ? 32'h00200081 : 32'h00200043);
   endproperty
   a_rid: assert property (p_rid) else $error("bad resource id");
   property p_first;
      $rose(tx_valid_o) |-> tx_data_o == 8'h9F;
   endproperty
   a_first: assert property (p_first) else $error("bad tag byte");
   property p_hold;
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("byte not held");
   property p_cnf;
      s_hdr ##1 rx_valid_i && rx_data_i == 8'h05 ##1
      rx_valid_i && rx_data_i == 8'h01 ##1 rx_valid_i |=> cnf_valid_o &&
      cnf_kind_o == 2'h0 && cnf_status_o == $past(rx_data_i);
   endproperty
   a_cnf: assert property (p_cnf) else $error("confirm lost");
   property p_drop;
      s_hdr ##1 rx_valid_i && rx_data_i == 8'h0A ##1
      rx_valid_i && rx_data_i == 8'h01 ##1 rx_valid_i |=> drop_o;
   endproperty
   a_drop: assert property (p_drop) else $error("unknown kept");
   property p_absent;
      cnf_valid_o && cnf_kind_o == 2'h0 && cnf_status_o == 8'h01 |=>
         upstream_absent_o [*3];
   endproperty
   a_absent: assert property (p_absent) else $error("absent lost");
   property p_noreq;
      req_valid_i && req_ready_o && req_kind_i == 2'h0 && (upstream_absent_o
      || req_rate_i[7:6] == 2'h1) |=> req_refused_o && !tx_valid_o;
   endproperty
   a_noreq: assert property (p_noreq) else $error("bad send");
   property p_kind3;
      req_valid_i && req_ready_o && req_kind_i == 2'h3 |=> req_refused_o;
   endproperty
   a_kind3: assert property (p_kind3) else $error("kind kept");
   // Main scenarios reached.
   c_dup: cover property (sess_dup_o);
   c_drop: cover property (drop_o);
   c_absent: cover property (upstream_absent_o && req_refused_o);
endmodule

bind hsttc_card_ctrl hsttc_mon u_mon (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .sess_open_req_i(sess_open_req_i),
   .multi_stream_i(multi_stream_i), .session_open_o(session_open_o),
   .sess_dup_o(sess_dup_o), .resource_id_o(resource_id_o),
   .req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
   .req_rate_i(req_rate_i), .req_ready_o(req_ready_o),
   .req_refused_o(req_refused_o), .cnf_valid_o(cnf_valid_o),
   .cnf_kind_o(cnf_kind_o), .cnf_status_o(cnf_status_o), .drop_o(drop_o),
   .upstream_absent_o(upstream_absent_o), .tx_data_o(tx_data_o),
   .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
   .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i));

// ==== testbench/hsttc_host_model.sv ====
`timescale 1ns/1ps
// Host end: takes tune requests, answers each with a confirmation, or with an unknown tag when bad_tag_i is set.
module hsttc_host_model (
   // Clock and reset.
   input  wire        clk_i,
   input  wire        rst_b_i,
   // Scenario controls.
   input  wire        stall_i,
   input  wire        grant_i,
   input  wire        bad_tag_i,
   input  wire        long_len_i,
   input  wire [7:0]  status_i,
   // Byte link.
   input  wire [7:0]  tx_data_i,
   input  wire        tx_valid_i,
   output wire        tx_ready_o,
   output reg  [7:0]  rx_data_o,
   output reg         rx_valid_o,
   // Last whole request taken.
   output reg  [63:0] cap_o
);
   reg  [63:0] got_r;  // Bytes of the message in flight.
   reg  [3:0]  n_r;    // Bytes taken so far.
   reg  [7:0]  len_r;  // Payload length.
   reg  [7:0]  tl_r;   // Low tag byte.
   reg  [47:0] out_r;  // Reply still to send.
   reg  [2:0]  cnt_r;  // Reply bytes left.
   wire        take = tx_valid_i && tx_ready_o;
   // Forward tuner is refused without a homing grant.
   wire [7:0]  st = (tl_r == 8'h08 && !grant_i) ? 8'h04 : status_i;
   // Low tag byte of the reply; a bad tag names no known message.
   wire [7:0]  tg = bad_tag_i ? 8'h0A : tl_r + 8'h01;
   assign tx_ready_o = !stall_i;
   // Collects requests and plays out replies.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         got_r <= 64'h0;
         n_r <= 4'h0;
         len_r <= 8'h00;
         tl_r <= 8'h00;
         out_r <= 48'h0;
         cnt_r <= 3'h0;
         rx_valid_o <= 1'b0;
         rx_data_o <= 8'h00;
         cap_o <= 64'h0;
      end else begin
         if (cnt_r != 3'h0) begin
            rx_valid_o <= 1'b1;
            rx_data_o <= out_r[47:40];
            out_r <= {out_r[39:0], 8'h00};
            cnt_r <= cnt_r - 3'h1;
         end else begin
            // Idle line toggles so stale data never looks valid.
            rx_valid_o <= 1'b0;
            rx_data_o <= ~rx_data_o;
         end
         if (take) begin
            got_r <= {got_r[55:0], tx_data_i};
            n_r <= n_r + 4'h1;
            if (n_r == 4'h2) tl_r <= tx_data_i;
            if (n_r == 4'h3) len_r <= tx_data_i;
            if (n_r >= 4'h4 && n_r == len_r[3:0] + 4'h3) begin
               cap_o <= {got_r[55:0], tx_data_i};
               got_r <= 64'h0;
               n_r <= 4'h0;
               // Long form announces one length byte before the count.
               out_r <= long_len_i ? {16'h9F84, tg, 8'h81, 8'h01, st} :
                        {16'h9F84, tg, 8'h01, st, 8'h00};
               cnt_r <= long_len_i ? 3'h6 : 3'h5;
            end
         end
      end
   end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// Drives the controller against the host model.
module tb;
   reg clk_i = 0, rst_b_i = 0, op = 0, cl = 0, ms = 0, rv = 0, alt = 0;
   reg stall = 0, stall_en = 0, grant = 1, bad = 0, lng = 0;
   reg [1:0] rk = 0, k;
   reg [15:0] rf = 0;
   reg [7:0] rl = 0, rr = 0, st = 0, r;
   reg [31:0] rnd = 32'hAB10;
   integer errors = 0, n_checks = 0, j;
   wire sopen, dup, rdy, refd, need, cv, drop, absent, txv, txr, rxv, bsy;
   wire [31:0] rid;
   wire [1:0] ck;
   wire [7:0] cs, txd, rxd;
   wire [63:0] cap;
   always #5 clk_i = ~clk_i;
   hsttc_card_ctrl DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .sess_open_req_i(op), .sess_close_req_i(cl), .multi_stream_i(ms),
      .session_open_o(sopen), .sess_dup_o(dup), .resource_id_o(rid),
      .req_valid_i(rv), .req_kind_i(rk), .req_freq_i(rf), .req_level_i(rl),
      .req_rate_i(rr), .alternate_signaling_option_i(alt),
      .req_ready_o(rdy), .req_refused_o(refd), .upstream_needed_o(need),
      .cnf_valid_o(cv), .cnf_kind_o(ck), .cnf_status_o(cs), .drop_o(drop),
      .upstream_absent_o(absent), .busy_o(bsy), .tx_data_o(txd),
      .tx_valid_o(txv), .tx_ready_i(txr), .rx_data_i(rxd), .rx_valid_i(rxv));
   hsttc_host_model u_host (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .stall_i(stall), .grant_i(grant), .bad_tag_i(bad),
      .long_len_i(lng), .status_i(st),
      .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
      .rx_data_o(rxd), .rx_valid_o(rxv), .cap_o(cap));
   // Next pseudo-random word.
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Request bytes expected on the link, right aligned.
   function [63:0] exp_msg(input [1:0] a, input [15:0] f, input [7:0] l, q);
      case (a)
         2'h0: exp_msg = {24'h9F8404, 8'h04, f, l, q & 8'hC0};
         2'h1: exp_msg = {8'h00, 24'h9F8406, 8'h03, f, q};
         default: exp_msg = {24'h9F8408, 8'h04, 8'h01, f, l};
      endcase
   endfunction
   // Random word and link stalls.
   always @(posedge clk_i) begin
      rnd <= lfsr(rnd);
      stall <= stall_en & rnd[3];
   end
   task chk(input bit ok, input string m);
      begin
         n_checks = n_checks + 1;
         if (!ok) begin
            errors = errors + 1;
            $display("[ERR] %0t %s", $time, m);
         end
      end
   endtask
   task final_report;
      begin
         $display("errors=%0d checks=%0d", errors, n_checks);
         if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Bounded wait: 0 ready, 1 confirm, 2 drop.
   task waitf(input [1:0] s);
      integer i;
      begin
         i = 0;
         while (!(s == 0 ? rdy === 1'b1 : s == 1 ? cv === 1'b1 :
                  drop === 1'b1) && i < 300) begin
            @(negedge clk_i);
            i = i + 1;
         end
         if (i >= 300) begin
            chk(0, "timeout");
            final_report;
         end
      end
   endtask
   task sess(input o, input c, input m);
      begin
         @(posedge clk_i);
         op <= o;
         cl <= c;
         ms <= m;
         @(posedge clk_i);
         op <= 0;
         cl <= 0;
         @(negedge clk_i);
      end
   endtask
   // One tune request and, unless refused or answered with a bad tag, its confirmation.
   task req(input [1:0] a, input [15:0] f, input [7:0] l, q, input bit n);
      begin
         waitf(0);
         @(posedge clk_i);
         rv <= 1;
         rk <= a;
         rf <= f;
         rl <= l;
         rr <= q;
         @(posedge clk_i);
         rv <= 0;
         @(negedge clk_i);
         chk(refd === n, "refuse flag");
         if (!n && !bad) begin
            waitf(1);
            chk(bsy === 1'b1, "busy");
            chk(ck === a, "confirm kind");
            chk(cs === ((a == 2 && !grant) ? 8'h04 : st), "status");
            chk(cap === exp_msg(a, f, l, q), "bytes");
         end
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1;
      @(negedge clk_i);
      chk(sopen === 1'b0 && rid === 32'h00200043 && ck === 2'h3, "rst");
      chk(bsy === 1'b0, "busy rst");
      req(0, 16'h1234, 8'h10, 8'h80, 1);
      sess(1, 0, 1);
      chk(sopen === 1'b1 && rid === 32'h00200081, "multi");
      sess(1, 0, 0);
      chk(dup === 1'b1 && rid === 32'h00200081, "dup");
      sess(0, 1, 0);
      sess(1, 0, 0);
      chk(rid === 32'h00200043, "single");
      repeat (2) @(negedge clk_i);
      chk(need === 1'b1, "need");
      @(posedge clk_i);
      alt <= 1;
      repeat (3) @(negedge clk_i);
      chk(need === 1'b0, "alt");
      @(posedge clk_i);
      alt <= 0;
      stall_en = 1;
      req(0, 16'hFFFF, 8'hFF, 8'hFF, 0);
      req(1, 16'h0000, 8'h00, 8'h41, 0);
      for (j = 0; j < 24; j = j + 1) begin
         k = (rnd[9:8] == 2'h3) ? 2'h0 : rnd[9:8];
         r = rnd[23:16] | 8'h80;
         st = (rnd[13:12] == 2'h0) ? 8'h00 : {6'h00, rnd[13:12]} + 8'h01;
         grant = rnd[15];
         lng = rnd[4];
         req(k, rnd[31:16], rnd[7:0] ^ 8'h5A, r, 0);
      end
      req(0, 16'h0100, 8'h02, 8'h40, 1);
      req(3, 16'h0100, 8'h02, 8'h80, 1);
      bad = 1;
      lng = 0;
      req(1, 16'h0300, 8'h00, 8'h00, 0);
      waitf(2);
      chk(drop === 1'b1, "drop");
      bad = 0;
      sess(0, 1, 0);
      sess(1, 0, 0);
      st = 8'h01;
      req(0, 16'h0200, 8'h08, 8'h80, 0);
      @(negedge clk_i);
      chk(absent === 1'b1, "absent");
      req(0, 16'h0200, 8'h08, 8'h80, 1);
      st = 8'h00;
      req(1, 16'h0400, 8'h09, 8'hC1, 0);
      final_report;
   end
endmodule
